// ---- core/fdcs_cfg.svh ----
// Offsets, field positions, reset values and widths of the clock system.
`ifndef FDCS_CFG_SVH
`define FDCS_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define FDCS_ADDR_W 8
`define FDCS_OFF_CLOCK_SELECT 8'h00
`define FDCS_OFF_OSC_CTRL 8'h04
`define FDCS_OFF_FAULT_FLAG 8'h08
`define FDCS_OFF_REQUEST_MASK 8'h0C
`define FDCS_OFF_LOOP_CTRL 8'h10
`define FDCS_OFF_TAP_MOD 8'h14
`define FDCS_OFF_STATUS 8'h18

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define FDCS_SEL_W 3
`define FDCS_SEL_MAIN_LSB 0
`define FDCS_SEL_SUB_LSB 4
`define FDCS_SEL_AUX_LSB 8
`define FDCS_OSC_FIRST_BYPASS 0
`define FDCS_OSC_SECOND_BYPASS 1
`define FDCS_OSC_FIRST_HF 2
`define FDCS_OSC_FIRST_ON 3
`define FDCS_OSC_SECOND_ON 4
`define FDCS_FLT_FIRST 0
`define FDCS_FLT_SECOND 1
`define FDCS_FLT_DCO 2
`define FDCS_FLT_SUMMARY 3
`define FDCS_REQ_AUX 0
`define FDCS_REQ_SUB 1
`define FDCS_REQ_MAIN 2
`define FDCS_LOOP_TARGET_LSB 0
`define FDCS_LOOP_OFF 16
`define FDCS_LOOP_NMI_EN 17
`define FDCS_TM_MOD_LSB 0
`define FDCS_TM_TAP_LSB 8
`define FDCS_ST_LEVEL_LSB 0
`define FDCS_ST_LOOP_ON 4
`define FDCS_ST_LOW_CURRENT 5
`define FDCS_ST_SERIAL_CLK 6
`define FDCS_ST_STATE_LSB 8

// ----------------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------------
`define FDCS_TAP_W 5
`define FDCS_MOD_W 5
`define FDCS_TARGET_W 12
`define FDCS_TAP_RESET 5'h0C
`define FDCS_MOD_RESET 5'h00
`define FDCS_TARGET_RESET 12'h0100
`define FDCS_REQ_RESET 3'h7

`endif

// ---- core/fdcs_pkg.sv ----
// Types shared by the clock system modules.
package fdcs_pkg;

  typedef enum logic [2:0] {
    FDCS_SRC_FIRST_OSC,
    FDCS_SRC_LOW_OSC,
    FDCS_SRC_REF_OSC,
    FDCS_SRC_DCO,
    FDCS_SRC_DCO_DIV,
    FDCS_SRC_SECOND_OSC
  } fdcs_src_e;

  typedef enum logic [2:0] {
    FDCS_ACTIVE,
    FDCS_LVL_ZERO,
    FDCS_LVL_ONE,
    FDCS_LVL_TWO,
    FDCS_LVL_THREE,
    FDCS_LVL_FOUR
  } fdcs_power_e;

  typedef enum logic [1:0] {
    FDCS_LOOP_IDLE,
    FDCS_LOOP_SYNC,
    FDCS_LOOP_MEASURE,
    FDCS_LOOP_APPLY
  } fdcs_loop_state_e;

  typedef struct packed {
    fdcs_src_e aux;
    fdcs_src_e submain;
    fdcs_src_e main;
  } fdcs_clk_sel_s;

  typedef struct packed {
    logic secondOscOn;
    logic firstOscOn;
    logic firstOscHf;
    logic secondOscBypass;
    logic firstOscBypass;
  } fdcs_osc_ctrl_s;

  typedef struct packed {
    logic dcoFault;
    logic secondOscFault;
    logic firstOscFault;
  } fdcs_fault_s;

endpackage

// ---- core/fdcs_modulator.sv ----
// Spreads higher-tap periods evenly across a modulation frame.
`timescale 1ns/1ns
`default_nettype none
module fdcs_modulator #(
  parameter int MOD_W = 5
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic periodTick,
  input wire logic [MOD_W-1:0] modValue,
  output logic useHigher_q
);

  logic [MOD_W-1:0] acc_q;
  logic [MOD_W-1:0] acc_d;
  logic useHigher_d;
  logic [MOD_W:0] sum;

  // An accumulator overflows exactly modValue times per frame of 2**MOD_W periods.
  always_comb begin
    sum = {1'b0, acc_q} + {1'b0, modValue};
    acc_d = acc_q;
    useHigher_d = useHigher_q;
    if (periodTick) begin
      acc_d = sum[MOD_W-1:0];
      useHigher_d = sum[MOD_W];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      acc_q <= '0;
      useHigher_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      useHigher_q <= useHigher_d;
    end
  end

endmodule
`default_nettype wire

// ---- core/fdcs_clock_system.sv ----
// Clock system: loop tuning, source select, fault flags and clock gating.
//
// Notes on behaviour
// R01: Loop counts oscillator edges between reference rising edges, then tunes tap and modulation.
// R02: One step: two reference periods of capture, then one reference period to apply.
// R03: Loop off at level zero without aux/sub use, and at levels two-four with gen-off.
// R04: Loop enabled on interrupt entry from level zero or two, and in active mode.
// R05: Modulator alternates between the selected tap and the next higher tap.
// R06: Tap and modulation step as one number, so modulation rolls over cleanly.
// R07: Select writes switch clocks; faults set only for enabled oscillators.
// R08: Fault summary raises the non-maskable request when that source is enabled.
// R09: Software clears each fault flag by writing one; hardware set wins.
// R10: Serial clock stops at levels three-four when idle, asynchronous and out of reset.
// R11: Level four gives low-current mode unless the second bypass, or the first bypass with high frequency, is still on.
// R12: Clearing the first oscillator bypass bit ends its bypass mode.
// R13: Software waits thirty-two by thirty-two reference periods before trusting lock.
// R14: Loop stays off at level one, also inside interrupts from it.
// R15: Loop stays on at level zero while oscillator drives aux or sub-main.
// R16: Peripheral clock requests are masked by one enable bit per clock.
// R17: Five-bit modulation spreads higher-tap periods evenly in a 32-period frame.
// R18: After reset faults are clear, loop enabled, tap and modulation at defaults.
`timescale 1ns/1ns
`default_nettype none
`include "fdcs_cfg.svh"
module fdcs_clock_system import fdcs_pkg::*; #(
  parameter int CNT_W = 12,
  parameter int TAP_W = 5,
  parameter int MOD_W = 5
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata_q,
  output logic hreadyout_q,
  output logic hresp_q,
  input wire logic loopRefClk,
  input wire logic dcoClk,
  input wire logic firstOscFaultRaw,
  input wire logic secondOscFaultRaw,
  input wire fdcs_power_e powerLevel,
  input wire logic isrActive,
  input wire logic clockGenOffTwo,
  input wire logic serialSoftReset,
  input wire logic serialAsync,
  input wire logic serialBusy,
  input wire logic serialClkReq,
  input wire logic auxReq,
  input wire logic subReq,
  input wire logic mainReq,
  output fdcs_clk_sel_s clkSel_q,
  output logic [TAP_W-1:0] dcoTap_q,
  output logic useHigherTap_q,
  output logic nmiReq_q,
  output logic auxClkEn_q,
  output logic subClkEn_q,
  output logic mainClkEn_q,
  output logic serialClkEn_q,
  output logic lowCurrentMode_q,
  output logic firstOscBypassOn_q,
  output logic loopActive_q
);

  localparam int TM_W = TAP_W + MOD_W;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [3:0] syncA_q;
  logic [3:0] syncB_q;
  logic [1:0] syncC_q;
  logic refRise;
  logic dcoRise;

  always_ff @(posedge mclk) begin
    if (rst) begin
      syncA_q <= 4'h0;
      syncB_q <= 4'h0;
      syncC_q <= 2'h0;
    end else begin
      syncA_q <= {secondOscFaultRaw, firstOscFaultRaw, dcoClk, loopRefClk};
      syncB_q <= syncA_q;
      syncC_q <= syncB_q[1:0];
    end
  end

  assign refRise = syncB_q[0] & ~syncC_q[0];
  assign dcoRise = syncB_q[1] & ~syncC_q[1];

  // --------------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------------
  logic accept;
  logic wrPend_q;
  logic wrPend_d;
  logic [`FDCS_ADDR_W-1:0] wrAddr_q;
  logic [`FDCS_ADDR_W-1:0] wrAddr_d;
  logic [31:0] hrdata_d;
  logic [31:0] readWord;
  logic wrSel;
  logic wrOsc;
  logic wrFault;
  logic wrReq;
  logic wrLoop;
  logic wrTm;

  fdcs_osc_ctrl_s osc_q;
  fdcs_osc_ctrl_s osc_d;
  fdcs_fault_s fault_q;
  fdcs_fault_s fault_d;
  fdcs_clk_sel_s clkSel_d;
  logic [2:0] clock_request_enable_q;
  logic [2:0] clock_request_enable_d;
  logic [`FDCS_TARGET_W-1:0] target_q;
  logic [`FDCS_TARGET_W-1:0] target_d;
  logic loopOff_q;
  logic loopOff_d;
  logic nmiEn_q;
  logic nmiEn_d;
  logic [TM_W-1:0] tapMod_q;
  logic [TM_W-1:0] tapMod_d;
  fdcs_loop_state_e state_q;
  logic loopEn;
  logic faultSummary;

  assign accept = hsel & hready & htrans[1];
  assign faultSummary = |fault_q;

  always_comb begin
    readWord = 32'h0000_0000;
    case (haddr[`FDCS_ADDR_W-1:0])
      `FDCS_OFF_CLOCK_SELECT: begin
        readWord[`FDCS_SEL_MAIN_LSB +: `FDCS_SEL_W] = clkSel_q.main;
        readWord[`FDCS_SEL_SUB_LSB +: `FDCS_SEL_W] = clkSel_q.submain;
        readWord[`FDCS_SEL_AUX_LSB +: `FDCS_SEL_W] = clkSel_q.aux;
      end
      `FDCS_OFF_OSC_CTRL: begin
        readWord[`FDCS_OSC_FIRST_BYPASS] = osc_q.firstOscBypass;
        readWord[`FDCS_OSC_SECOND_BYPASS] = osc_q.secondOscBypass;
        readWord[`FDCS_OSC_FIRST_HF] = osc_q.firstOscHf;
        readWord[`FDCS_OSC_FIRST_ON] = osc_q.firstOscOn;
        readWord[`FDCS_OSC_SECOND_ON] = osc_q.secondOscOn;
      end
      `FDCS_OFF_FAULT_FLAG: begin
        readWord[`FDCS_FLT_FIRST] = fault_q.firstOscFault;
        readWord[`FDCS_FLT_SECOND] = fault_q.secondOscFault;
        readWord[`FDCS_FLT_DCO] = fault_q.dcoFault;
        readWord[`FDCS_FLT_SUMMARY] = faultSummary;
      end
      `FDCS_OFF_REQUEST_MASK: begin
        readWord[`FDCS_REQ_AUX] = clock_request_enable_q[`FDCS_REQ_AUX];
        readWord[`FDCS_REQ_SUB] = clock_request_enable_q[`FDCS_REQ_SUB];
        readWord[`FDCS_REQ_MAIN] = clock_request_enable_q[`FDCS_REQ_MAIN];
      end
      `FDCS_OFF_LOOP_CTRL: begin
        readWord[`FDCS_LOOP_TARGET_LSB +: `FDCS_TARGET_W] = target_q;
        readWord[`FDCS_LOOP_OFF] = loopOff_q;
        readWord[`FDCS_LOOP_NMI_EN] = nmiEn_q;
      end
      `FDCS_OFF_TAP_MOD: begin
        readWord[`FDCS_TM_MOD_LSB +: MOD_W] = tapMod_q[MOD_W-1:0];
        readWord[`FDCS_TM_TAP_LSB +: TAP_W] = tapMod_q[TM_W-1:MOD_W];
      end
      `FDCS_OFF_STATUS: begin
        readWord[`FDCS_ST_LEVEL_LSB +: 3] = powerLevel;
        readWord[`FDCS_ST_LOOP_ON] = loopEn;
        readWord[`FDCS_ST_LOW_CURRENT] = lowCurrentMode_q;
        readWord[`FDCS_ST_SERIAL_CLK] = serialClkEn_q;
        readWord[`FDCS_ST_STATE_LSB +: 2] = state_q;
      end
      default: readWord = 32'h0000_0000;
    endcase
  end

  // Reads are answered with no wait state; writes land in the data phase.
  always_comb begin
    wrPend_d = accept & hwrite;
    wrAddr_d = wrAddr_q;
    if (accept) begin
      wrAddr_d = haddr[`FDCS_ADDR_W-1:0];
    end
    hrdata_d = (accept & ~hwrite) ? readWord : 32'h0000_0000;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= '0;
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      wrPend_q <= wrPend_d;
      wrAddr_q <= wrAddr_d;
      hrdata_q <= hrdata_d;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  assign wrSel = wrPend_q & (wrAddr_q == `FDCS_OFF_CLOCK_SELECT);
  assign wrOsc = wrPend_q & (wrAddr_q == `FDCS_OFF_OSC_CTRL);
  assign wrFault = wrPend_q & (wrAddr_q == `FDCS_OFF_FAULT_FLAG);
  assign wrReq = wrPend_q & (wrAddr_q == `FDCS_OFF_REQUEST_MASK);
  assign wrLoop = wrPend_q & (wrAddr_q == `FDCS_OFF_LOOP_CTRL);
  assign wrTm = wrPend_q & (wrAddr_q == `FDCS_OFF_TAP_MOD);

  // --------------------------------------------------------------------------
  // Frequency-locked loop
  // --------------------------------------------------------------------------
  fdcs_loop_state_e state_d;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic refSeen_q;
  logic refSeen_d;
  logic tooSlow_q;
  logic tooSlow_d;
  logic tooFast_q;
  logic tooFast_d;
  logic adjUp;
  logic adjDown;
  logic dcoFeedsPeriph;

  assign dcoFeedsPeriph = (clkSel_q.aux == FDCS_SRC_DCO) | (clkSel_q.aux == FDCS_SRC_DCO_DIV) |
                          (clkSel_q.submain == FDCS_SRC_DCO) | (clkSel_q.submain == FDCS_SRC_DCO_DIV);

  always_comb begin
    loopEn = 1'b0;
    case (powerLevel)
      FDCS_ACTIVE: loopEn = 1'b1; // R04
      FDCS_LVL_ZERO: loopEn = isrActive | dcoFeedsPeriph; // R03 R04 R15
      FDCS_LVL_ONE: loopEn = 1'b0; // R14
      FDCS_LVL_TWO: loopEn = isrActive | ~clockGenOffTwo; // R03 R04
      FDCS_LVL_THREE: loopEn = ~clockGenOffTwo; // R03
      FDCS_LVL_FOUR: loopEn = ~clockGenOffTwo; // R03
      default: loopEn = 1'b0;
    endcase
    if (loopOff_q) begin
      loopEn = 1'b0;
    end
  end

  // Comparison starts at the first reference edge after enabling.
  always_comb begin
    state_d = state_q;
    count_d = count_q;
    refSeen_d = refSeen_q;
    tooSlow_d = tooSlow_q;
    tooFast_d = tooFast_q;
    adjUp = 1'b0;
    adjDown = 1'b0;
    if (dcoRise && count_q != {CNT_W{1'b1}}) begin
      count_d = count_q + 1'b1; // R01
    end
    case (state_q)
      FDCS_LOOP_IDLE: begin
        if (loopEn) begin
          state_d = FDCS_LOOP_SYNC; // R04
        end
      end
      FDCS_LOOP_SYNC: begin
        if (refRise) begin
          state_d = FDCS_LOOP_MEASURE;
          count_d = '0;
          refSeen_d = 1'b0;
        end
      end
      FDCS_LOOP_MEASURE: begin
        if (refRise) begin
          refSeen_d = 1'b1;
          if (refSeen_q) begin
            state_d = FDCS_LOOP_APPLY; // R02
            tooSlow_d = count_q < CNT_W'(target_q); // R01
            tooFast_d = count_q > CNT_W'(target_q); // R01
          end
        end
      end
      FDCS_LOOP_APPLY: begin
        if (refRise) begin
          state_d = FDCS_LOOP_MEASURE; // R02
          count_d = '0;
          refSeen_d = 1'b0;
          adjUp = tooSlow_q;
          adjDown = tooFast_q;
        end
      end
      default: state_d = FDCS_LOOP_IDLE;
    endcase
    if (!loopEn) begin
      state_d = FDCS_LOOP_IDLE;
      adjUp = 1'b0;
      adjDown = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= FDCS_LOOP_IDLE;
      count_q <= '0;
      refSeen_q <= 1'b0;
      tooSlow_q <= 1'b0;
      tooFast_q <= 1'b0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      refSeen_q <= refSeen_d;
      tooSlow_q <= tooSlow_d;
      tooFast_q <= tooFast_d;
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic tmAtMax;
  logic tmAtMin;

  assign tmAtMax = &tapMod_q;
  assign tmAtMin = ~|tapMod_q;

  always_comb begin
    clkSel_d = clkSel_q;
    osc_d = osc_q;
    clock_request_enable_d = clock_request_enable_q;
    target_d = target_q;
    loopOff_d = loopOff_q;
    nmiEn_d = nmiEn_q;
    tapMod_d = tapMod_q;
    fault_d = fault_q;
    if (wrSel) begin
      clkSel_d.main = fdcs_src_e'(hwdata[`FDCS_SEL_MAIN_LSB +: `FDCS_SEL_W]); // R07
      clkSel_d.submain = fdcs_src_e'(hwdata[`FDCS_SEL_SUB_LSB +: `FDCS_SEL_W]); // R07
      clkSel_d.aux = fdcs_src_e'(hwdata[`FDCS_SEL_AUX_LSB +: `FDCS_SEL_W]); // R07
    end
    if (wrOsc) begin
      osc_d.firstOscBypass = hwdata[`FDCS_OSC_FIRST_BYPASS]; // R12
      osc_d.secondOscBypass = hwdata[`FDCS_OSC_SECOND_BYPASS];
      osc_d.firstOscHf = hwdata[`FDCS_OSC_FIRST_HF];
      osc_d.firstOscOn = hwdata[`FDCS_OSC_FIRST_ON];
      osc_d.secondOscOn = hwdata[`FDCS_OSC_SECOND_ON];
    end
    if (wrReq) begin
      clock_request_enable_d = hwdata[`FDCS_REQ_AUX +: 3]; // R16
    end
    if (wrLoop) begin
      target_d = hwdata[`FDCS_LOOP_TARGET_LSB +: `FDCS_TARGET_W];
      loopOff_d = hwdata[`FDCS_LOOP_OFF];
      nmiEn_d = hwdata[`FDCS_LOOP_NMI_EN];
    end
    // Tap and modulation step as one number, so a carry lands in the tap.
    if (adjUp && !tmAtMax) begin
      tapMod_d = tapMod_q + 1'b1; // R06
    end else if (adjDown && !tmAtMin) begin
      tapMod_d = tapMod_q - 1'b1; // R06
    end
    if (wrTm) begin
      tapMod_d = {hwdata[`FDCS_TM_TAP_LSB +: TAP_W], hwdata[`FDCS_TM_MOD_LSB +: MOD_W]};
    end
    if (wrFault) begin
      fault_d.firstOscFault = fault_q.firstOscFault & ~hwdata[`FDCS_FLT_FIRST]; // R09
      fault_d.secondOscFault = fault_q.secondOscFault & ~hwdata[`FDCS_FLT_SECOND]; // R09
      fault_d.dcoFault = fault_q.dcoFault & ~hwdata[`FDCS_FLT_DCO]; // R09
    end
    // Faults of absent or switched-off oscillators are never raised, whatever a select write does.
    if (syncB_q[2] && osc_q.firstOscOn) begin
      fault_d.firstOscFault = 1'b1; // R07
    end
    if (syncB_q[3] && osc_q.secondOscOn) begin
      fault_d.secondOscFault = 1'b1; // R07
    end
    if ((adjUp && tmAtMax) || (adjDown && tmAtMin)) begin
      fault_d.dcoFault = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      clkSel_q <= '{aux: FDCS_SRC_FIRST_OSC, submain: FDCS_SRC_DCO_DIV, main: FDCS_SRC_DCO_DIV};
      osc_q <= '0;
      clock_request_enable_q <= `FDCS_REQ_RESET;
      target_q <= `FDCS_TARGET_RESET;
      loopOff_q <= 1'b0; // R18
      nmiEn_q <= 1'b0;
      tapMod_q <= {`FDCS_TAP_RESET, `FDCS_MOD_RESET}; // R18
      fault_q <= '0; // R18
    end else begin
      clkSel_q <= clkSel_d;
      osc_q <= osc_d;
      clock_request_enable_q <= clock_request_enable_d;
      target_q <= target_d;
      loopOff_q <= loopOff_d;
      nmiEn_q <= nmiEn_d;
      tapMod_q <= tapMod_d;
      fault_q <= fault_d;
    end
  end

  // --------------------------------------------------------------------------
  // Modulator and clock outputs
  // --------------------------------------------------------------------------
  logic useHigher;
  logic [TAP_W-1:0] tapField;
  logic [TAP_W-1:0] dcoTap_d;
  logic deepSleep;
  logic nmiReq_d;
  logic auxClkEn_d;
  logic subClkEn_d;
  logic mainClkEn_d;
  logic serialClkEn_d;
  logic lowCurrentMode_d;

  assign tapField = tapMod_q[TM_W-1:MOD_W];

  fdcs_modulator #(
    .MOD_W(MOD_W)
  ) u_modulator (
    .mclk(mclk),
    .rst(rst),
    .periodTick(dcoRise),
    .modValue(tapMod_q[MOD_W-1:0]), // R17
    .useHigher_q(useHigher)
  );

  assign deepSleep = (powerLevel == FDCS_LVL_THREE) | (powerLevel == FDCS_LVL_FOUR);

  always_comb begin
    dcoTap_d = tapField;
    if (useHigher && !(&tapField)) begin
      dcoTap_d = tapField + 1'b1; // R05
    end
    nmiReq_d = faultSummary & nmiEn_q; // R08
    mainClkEn_d = (powerLevel == FDCS_ACTIVE) | isrActive | (mainReq & clock_request_enable_q[`FDCS_REQ_MAIN]); // R16
    subClkEn_d = (powerLevel == FDCS_ACTIVE) | (powerLevel == FDCS_LVL_ZERO) | (powerLevel == FDCS_LVL_ONE) |
                 (subReq & clock_request_enable_q[`FDCS_REQ_SUB]); // R16
    auxClkEn_d = (powerLevel != FDCS_LVL_FOUR) | (auxReq & clock_request_enable_q[`FDCS_REQ_AUX]); // R16
    serialClkEn_d = serialClkReq & ~(deepSleep & ~serialSoftReset & serialAsync & ~serialBusy); // R10
    lowCurrentMode_d = (powerLevel == FDCS_LVL_FOUR) &
                       ~((osc_q.firstOscBypass & osc_q.firstOscHf) | osc_q.secondOscBypass); // R11
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      dcoTap_q <= `FDCS_TAP_RESET;
      useHigherTap_q <= 1'b0;
      nmiReq_q <= 1'b0;
      mainClkEn_q <= 1'b1;
      subClkEn_q <= 1'b1;
      auxClkEn_q <= 1'b1;
      serialClkEn_q <= 1'b0;
      lowCurrentMode_q <= 1'b0;
      firstOscBypassOn_q <= 1'b0;
      loopActive_q <= 1'b0;
    end else begin
      dcoTap_q <= dcoTap_d;
      useHigherTap_q <= useHigher;
      nmiReq_q <= nmiReq_d;
      mainClkEn_q <= mainClkEn_d;
      subClkEn_q <= subClkEn_d;
      auxClkEn_q <= auxClkEn_d;
      serialClkEn_q <= serialClkEn_d;
      lowCurrentMode_q <= lowCurrentMode_d;
      firstOscBypassOn_q <= osc_q.firstOscBypass; // R12
      loopActive_q <= loopEn;
    end
  end

endmodule
`default_nettype wire

// ---- verification/fdcs_clock_system_chk.sv ----
// Checker of the loop enable and clock gating relations of the clock system.
`timescale 1ns/1ns
`default_nettype none
module fdcs_clock_chk import fdcs_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  input wire fdcs_power_e powerLevel,
  input wire logic isrActive,
  input wire logic clockGenOffTwo,
  input wire logic serialSoftReset,
  input wire logic serialAsync,
  input wire logic serialBusy,
  input wire logic serialClkReq,
  input wire logic auxReq,
  input wire fdcs_clk_sel_s clkSel_q,
  input wire logic loopActive_q,
  input wire logic lowCurrentMode_q,
  input wire logic serialClkEn_q,
  input wire logic mainClkEn_q,
  input wire logic subClkEn_q,
  input wire logic auxClkEn_q
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  lvl_one_off_a: assert property (powerLevel == FDCS_LVL_ONE |=> !loopActive_q)
    else $error("loop active at level one");
  gen_off_a: assert property (powerLevel inside {FDCS_LVL_TWO, FDCS_LVL_THREE, FDCS_LVL_FOUR}
    && clockGenOffTwo && !isrActive |=> !loopActive_q) else $error("loop active with generator off");
  active_on_a: assert property (!rst && powerLevel == FDCS_ACTIVE |=> loopActive_q)
    else $error("loop idle in active mode");
  lvl_zero_on_a: assert property (powerLevel == FDCS_LVL_ZERO && (clkSel_q.aux == FDCS_SRC_DCO
    || clkSel_q.submain == FDCS_SRC_DCO) |=> loopActive_q) else $error("loop idle while sourcing clocks");
  low_cur_a: assert property (lowCurrentMode_q |-> $past(powerLevel) == FDCS_LVL_FOUR)
    else $error("low current outside level four");
  serial_idle_a: assert property (powerLevel inside {FDCS_LVL_THREE, FDCS_LVL_FOUR} && !serialSoftReset
    && serialAsync && !serialBusy |=> !serialClkEn_q) else $error("idle serial clock kept on");
  serial_req_a: assert property (!serialClkReq |=> !serialClkEn_q)
    else $error("serial clock without request");
  active_en_a: assert property (powerLevel == FDCS_ACTIVE |=> mainClkEn_q && subClkEn_q && auxClkEn_q)
    else $error("clock gated in active mode");
  aux_gate_a: assert property (powerLevel == FDCS_LVL_FOUR && !auxReq |=> !auxClkEn_q)
    else $error("aux clock on at level four");
endmodule
bind fdcs_clock_system fdcs_clock_chk fdcs_clock_chk_i (.mclk, .rst, .powerLevel, .isrActive,
  .clockGenOffTwo, .serialSoftReset, .serialAsync, .serialBusy, .serialClkReq, .auxReq, .clkSel_q,
  .loopActive_q, .lowCurrentMode_q, .serialClkEn_q, .mainClkEn_q, .subClkEn_q, .auxClkEn_q);
`default_nettype wire

// ---- verification/fdcs_osc_model.sv ----
// Free-running reference and oscillator clock sources.
`timescale 1ns/1ns
`default_nettype none
module fdcs_osc_model #(
  parameter int REF_HALF = 161,
  parameter int DCO_HALF = 10
) (
  output logic loopRefClk,
  output logic dcoClk
);
  // Both sources run free and unrelated in phase to the system clock.
  initial begin
    loopRefClk = 1'b0;
    forever #(REF_HALF) loopRefClk = ~loopRefClk;
  end
  initial begin
    dcoClk = 1'b1;
    #3;
    forever #(DCO_HALF) dcoClk = ~dcoClk;
  end
endmodule
`default_nettype wire

// ---- verification/tb_fdcs_clock_system.sv ----
// Self-checking testbench of the clock system.
`timescale 1ns/1ns
`default_nettype none
module tb_fdcs_clock_system import fdcs_pkg::*; ;
  localparam logic [31:0] Z = 32'h0000_0000;
  localparam logic [31:0] ON = 32'h0000_0001;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] haddr = Z;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = Z;
  logic [31:0] hrdata_q;
  logic [31:0] rv;
  logic hreadyout_q, hresp_q, loopRefClk, dcoClk;
  logic firstOscFaultRaw = 1'b0, secondOscFaultRaw = 1'b0;
  fdcs_power_e powerLevel = FDCS_ACTIVE;
  logic isrActive = 1'b0, clockGenOffTwo = 1'b0, serialSoftReset = 1'b0, serialAsync = 1'b1;
  logic serialBusy = 1'b0, serialClkReq = 1'b0, auxReq = 1'b0, subReq = 1'b0, mainReq = 1'b0;
  fdcs_clk_sel_s clkSel_q;
  logic [4:0] dcoTap_q;
  logic useHigherTap_q, nmiReq_q, auxClkEn_q, subClkEn_q, mainClkEn_q, serialClkEn_q;
  logic lowCurrentMode_q, firstOscBypassOn_q, loopActive_q;
  int errTotal = 0;
  int comparisons = 0;
  fdcs_clock_system fdcs_clock_system_i (.mclk, .rst, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hready(hreadyout_q), .hwdata, .hrdata_q, .hreadyout_q, .hresp_q, .loopRefClk,
    .dcoClk, .firstOscFaultRaw, .secondOscFaultRaw, .powerLevel, .isrActive, .clockGenOffTwo,
    .serialSoftReset, .serialAsync, .serialBusy, .serialClkReq, .auxReq, .subReq, .mainReq, .clkSel_q,
    .dcoTap_q, .useHigherTap_q, .nmiReq_q, .auxClkEn_q, .subClkEn_q, .mainClkEn_q, .serialClkEn_q,
    .lowCurrentMode_q, .firstOscBypassOn_q, .loopActive_q);
  fdcs_osc_model fdcs_osc_model_i (.loopRefClk, .dcoClk);
  initial begin
    forever #2 mclk = ~mclk;
  end
  task automatic endSim;
    if (errTotal == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      errTotal++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Bounded wait for ready.
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout_q !== 1'b1 && n < 64);
    if (hreadyout_q !== 1'b1) begin
      errTotal++;
      endSim;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    rv = hrdata_q;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, Z);
    chk(nm, rv, e);
  endtask
  task automatic tReset;
    chk("tap", 32'(dcoTap_q), 32'h0000_000C);
    chk("sel", 32'(clkSel_q), 32'h0000_0024);
    chk("nmi", 32'(nmiReq_q), Z);
    chk("resp", 32'(hresp_q), Z);
    rdc("tapmod", 8'h14, 32'h0000_0C00);
    rdc("fault", 8'h08, Z);
    rdc("mask", 8'h0C, 32'h0000_0007);
    rdc("unmapped", 8'h40, Z);
  endtask
  // The slow oscillator raises tap and modulation each step.
  task automatic tLoop;
    logic [9:0] v1;
    cyc(1900);
    bus(1'b0, 8'h14, Z);
    v1 = {rv[12:8], rv[4:0]};
    chk("steps", 32'(v1 >= 10'h186 && v1 <= 10'h188), ON);
    cyc(8000);
    bus(1'b0, 8'h14, Z);
    chk("rise", 32'({rv[12:8], rv[4:0]} > v1), ON);
    chk("tapnext", 32'(rv[12:8]), 32'h0000_000D);
    chk("dcotap", 32'(dcoTap_q == rv[12:8] || dcoTap_q == rv[12:8] + 5'h01), ON);
  endtask
  task automatic tSel;
    firstOscFaultRaw <= 1'b1;
    secondOscFaultRaw <= 1'b1;
    bus(1'b1, 8'h00, 32'h0000_0350);
    cyc(8);
    chk("sel", 32'(clkSel_q), 32'h0000_00E8);
    rdc("fault", 8'h08, Z);
  endtask
  task automatic tNmi;
    bus(1'b1, 8'h04, 32'h0000_0008);
    cyc(8);
    rdc("fault", 8'h08, 32'h0000_0009);
    bus(1'b1, 8'h10, 32'h0002_0100);
    cyc(3);
    chk("nmi", 32'(nmiReq_q), ON);
    firstOscFaultRaw <= 1'b0;
    secondOscFaultRaw <= 1'b0;
    cyc(6);
    bus(1'b1, 8'h08, 32'h0000_0007);
    cyc(2);
    rdc("fault", 8'h08, Z);
    chk("nmi", 32'(nmiReq_q), Z);
  endtask
  task automatic pw(input fdcs_power_e l, input logic i, input logic g, input logic e);
    powerLevel <= l;
    isrActive <= i;
    clockGenOffTwo <= g;
    cyc(3);
    chk("loop", 32'(loopActive_q), 32'(e));
  endtask
  task automatic tPow;
    int h = 0, t = 0;
    pw(FDCS_LVL_ONE, 1'b1, 1'b0, 1'b0);
    bus(1'b1, 8'h14, 32'h0000_0D0B);
    cyc(8);
    repeat (160) begin
      @(posedge mclk);
      h += useHigherTap_q;
      t += (dcoTap_q == 5'h0E);
    end
    chk("higher", h, 55);
    chk("tapup", t, 55);
    pw(FDCS_LVL_TWO, 1'b0, 1'b1, 1'b0);
    pw(FDCS_LVL_TWO, 1'b1, 1'b1, 1'b1);
    pw(FDCS_LVL_ZERO, 1'b0, 1'b0, 1'b1);
    bus(1'b1, 8'h00, Z);
    pw(FDCS_LVL_ZERO, 1'b0, 1'b0, 1'b0);
    pw(FDCS_LVL_ZERO, 1'b1, 1'b0, 1'b1);
    pw(FDCS_LVL_FOUR, 1'b0, 1'b1, 1'b0);
  endtask
  task automatic tLow;
    chk("low", 32'(lowCurrentMode_q), ON);
    bus(1'b1, 8'h04, 32'h0000_000D);
    cyc(3);
    chk("bypass", 32'(firstOscBypassOn_q), ON);
    chk("low", 32'(lowCurrentMode_q), Z);
    bus(1'b1, 8'h04, 32'h0000_000C);
    cyc(3);
    chk("bypass", 32'(firstOscBypassOn_q), Z);
    chk("low", 32'(lowCurrentMode_q), ON);
    auxReq <= 1'b1;
    subReq <= 1'b1;
    mainReq <= 1'b1;
    serialClkReq <= 1'b1;
    cyc(3);
    chk("req", 32'({auxClkEn_q, subClkEn_q, mainClkEn_q}), 32'h0000_0007);
    chk("serial", 32'(serialClkEn_q), Z);
    serialBusy <= 1'b1;
    bus(1'b1, 8'h0C, Z);
    cyc(3);
    chk("req", 32'({auxClkEn_q, subClkEn_q, mainClkEn_q}), Z);
    chk("serial", 32'(serialClkEn_q), ON);
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    tReset;
    tLoop;
    tSel;
    tNmi;
    tPow;
    tLow;
    endSim;
  end
endmodule
`default_nettype wire
